/* File: logic/iefl_params.svh */
// Constants for the interrupt enable and flag block
`ifndef IEFL_PARAMS_SVH
`define IEFL_PARAMS_SVH
`define IEFL_ADDR_CTRL       12'h00b
`define IEFL_ADDR_PIE        12'h08c
`define IEFL_ADDR_PFLAG      12'h090
`define IEFL_ADDR_STAT       12'h094
`define IEFL_ADDR_MASK       12'h098
`define IEFL_BIT_GIE         7
`define IEFL_BIT_PERIPHERAL_MASTER_ENABLE        6
`define IEFL_BIT_T0E         5
`define IEFL_BIT_EDE         4
`define IEFL_BIT_PCE         3
`define IEFL_BIT_T0F         2
`define IEFL_BIT_EDF         1
`define IEFL_BIT_PCF         0
`define IEFL_CTRL_RESET      8'h00
`define IEFL_PIE_RESET       8'h00
`define IEFL_PIE_WMASK       8'hcf
`define IEFL_ZERO8           8'h00
`define IEFL_ZERO32          32'h0000_0000
`define IEFL_NSRC            7
`endif

/* File: logic/iefl_pkg.sv */
// Types shared by the interrupt enable and flag block
package iefl_pkg;
  typedef logic [7:0]  iefl_byte_t;
  typedef logic [31:0] iefl_word_t;
  typedef logic [11:0] iefl_addr_t;
endpackage

/* File: logic/iefl_sync.sv */
// Three-stage synchroniser with second/third agreement
`timescale 1ns/1ns
module iefl_sync (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_d,
  output logic      o_q
);
  logic s1;
  logic s2;
  logic s3;
  wire  agree = (s2 == s3);
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1  <= 1'b0;
      s2  <= 1'b0;
      s3  <= 1'b0;
      o_q <= 1'b0;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
      if (agree) begin
        o_q <= s3;
      end
    end
  end
endmodule

/* File: logic/iefl_flag.sv */
// One sticky flag: hardware set wins over software clear
`timescale 1ns/1ns
module iefl_flag (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_flag
);
  // Set wins over clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end
endmodule

/* File: logic/iefl_top.sv */
// Interrupt enable and flag registers with APB access
`timescale 1ns/1ns
`include "iefl_params.svh"
module iefl_top (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire iefl_pkg::iefl_addr_t i_paddr,
  input  wire iefl_pkg::iefl_word_t i_pwdata,
  output iefl_pkg::iefl_word_t   o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_timer_zero_overflow,
  input  wire logic              i_external_edge_pin,
  input  wire logic              i_edge_rising,
  input  wire logic [3:0]        i_upper_port_pins,
  input  wire logic              i_serial_port_event,
  input  wire logic              i_capture_compare_one_event,
  input  wire logic              i_timer_two_match_event,
  input  wire logic              i_timer_one_overflow_event,
  output logic                   o_core_irq,
  output logic                   o_irq
);
  import iefl_pkg::*;

  iefl_byte_t ctrl_en;
  iefl_byte_t pie;
  iefl_byte_t stat_mask;
  logic [3:0] port_latch;
  logic       edge_prev;
  logic       t0f;
  logic       edf;
  logic       pcf;
  logic [3:0] pflag;
  logic [`IEFL_NSRC-1:0] stat;
  logic [3:0] port_sync;
  logic       edge_sync;

  // Pins from outside the clock domain
  iefl_sync u_sync_edge (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    (i_external_edge_pin),
    .o_q    (edge_sync)
  );
  iefl_sync u_sync_port0 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    (i_upper_port_pins[0]),
    .o_q    (port_sync[0])
  );

  iefl_sync u_sync_port1 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    (i_upper_port_pins[1]),
    .o_q    (port_sync[1])
  );

  iefl_sync u_sync_port2 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    (i_upper_port_pins[2]),
    .o_q    (port_sync[2])
  );

  iefl_sync u_sync_port3 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_d    (i_upper_port_pins[3]),
    .o_q    (port_sync[3])
  );

  // Bus decode; single-cycle access phase, zero wait states
  wire        setup_rd  = i_psel && !i_penable && !i_pwrite;
  wire        access    = i_psel && i_penable;
  wire        wr        = access && i_pwrite;
  wire        hit_ctrl  = (i_paddr == `IEFL_ADDR_CTRL);
  wire        hit_pie   = (i_paddr == `IEFL_ADDR_PIE);
  wire        hit_pflag = (i_paddr == `IEFL_ADDR_PFLAG);
  wire        hit_stat  = (i_paddr == `IEFL_ADDR_STAT);
  wire        hit_mask  = (i_paddr == `IEFL_ADDR_MASK);
  wire        hit_any   = hit_ctrl | hit_pie | hit_pflag | hit_stat | hit_mask;
  wire        wr_ctrl   = wr && hit_ctrl;
  wire        wr_pie    = wr && hit_pie;
  wire        wr_pflag  = wr && hit_pflag;
  wire        wr_stat   = wr && hit_stat;
  wire        wr_mask   = wr && hit_mask;
  wire [7:0]  wdat      = i_pwdata[7:0];
  wire        rd_ctrl   = access && !i_pwrite && hit_ctrl;

  // Event detection
  wire        edge_rise = edge_sync && !edge_prev;
  wire        edge_fall = !edge_sync && edge_prev;
  wire        edge_evt  = i_edge_rising ? edge_rise : edge_fall;
  // Mismatch against the last read value marks a port change
  wire        port_chg  = |(port_sync ^ port_latch);

  wire [7:0]  ctrl_rd = {ctrl_en[7:3], t0f, edf, pcf};
  // Bits 5:4 always read zero; unused bits 7:6 read back as written
  wire [7:0]  pie_rd  = pie & `IEFL_PIE_WMASK;
  wire [`IEFL_NSRC-1:0] evt_vec = {i_timer_one_overflow_event, i_timer_two_match_event,
                                   i_capture_compare_one_event, i_serial_port_event,
                                   port_chg, edge_evt, i_timer_zero_overflow};

  wire [31:0] rd_mux =
      hit_ctrl  ? {24'h00_0000, ctrl_rd} :
      hit_pie   ? {24'h00_0000, pie_rd} :
      hit_pflag ? {28'h000_0000, pflag} :
      hit_stat  ? {25'h000_0000, stat} :
      hit_mask  ? {24'h00_0000, stat_mask} : `IEFL_ZERO32;

  // Sticky flags, cleared by writing zero
  wire t0_clr = wr_ctrl && !wdat[`IEFL_BIT_T0F];
  wire ed_clr = wr_ctrl && !wdat[`IEFL_BIT_EDF];
  wire pc_clr = wr_ctrl && !wdat[`IEFL_BIT_PCF];

  iefl_flag u_t0f (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (i_timer_zero_overflow),
    .i_clr  (t0_clr),
    .o_flag (t0f)
  );
  iefl_flag u_edf (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (edge_evt),
    .i_clr  (ed_clr),
    .o_flag (edf)
  );
  iefl_flag u_pcf (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (port_chg),
    .i_clr  (pc_clr),
    .o_flag (pcf)
  );

  // Peripheral flags, same write-zero clearing
  // Bit order matches the enable register so flag and enable pair bit for bit
  wire [3:0] pf_clr = {4{wr_pflag}} & ~wdat[3:0];

  iefl_flag u_pf_serial (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (i_serial_port_event),
    .i_clr  (pf_clr[3]),
    .o_flag (pflag[3])
  );

  iefl_flag u_pf_ccp (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (i_capture_compare_one_event),
    .i_clr  (pf_clr[2]),
    .o_flag (pflag[2])
  );

  iefl_flag u_pf_tm2 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (i_timer_two_match_event),
    .i_clr  (pf_clr[1]),
    .o_flag (pflag[1])
  );

  iefl_flag u_pf_tm1 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (i_timer_one_overflow_event),
    .i_clr  (pf_clr[0]),
    .o_flag (pflag[0])
  );

  // Status of raw events, write one to clear
  wire [`IEFL_NSRC-1:0] st_clr = {`IEFL_NSRC{wr_stat}} & wdat[`IEFL_NSRC-1:0];

  iefl_flag u_st0 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (evt_vec[0]),
    .i_clr  (st_clr[0]),
    .o_flag (stat[0])
  );

  iefl_flag u_st1 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (evt_vec[1]),
    .i_clr  (st_clr[1]),
    .o_flag (stat[1])
  );

  iefl_flag u_st2 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (evt_vec[2]),
    .i_clr  (st_clr[2]),
    .o_flag (stat[2])
  );

  iefl_flag u_st3 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (evt_vec[3]),
    .i_clr  (st_clr[3]),
    .o_flag (stat[3])
  );

  iefl_flag u_st4 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (evt_vec[4]),
    .i_clr  (st_clr[4]),
    .o_flag (stat[4])
  );

  iefl_flag u_st5 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (evt_vec[5]),
    .i_clr  (st_clr[5]),
    .o_flag (stat[5])
  );

  iefl_flag u_st6 (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_set  (evt_vec[6]),
    .i_clr  (st_clr[6]),
    .o_flag (stat[6])
  );

  wire req_t0 = t0f && ctrl_en[`IEFL_BIT_T0E];
  wire req_ed = edf && ctrl_en[`IEFL_BIT_EDE];
  wire req_pc = pcf && ctrl_en[`IEFL_BIT_PCE];
  wire req_ser = pflag[3] && pie[3];
  wire req_ccp = pflag[2] && pie[2];
  wire req_tm2 = pflag[1] && pie[1];
  wire req_tm1 = pflag[0] && pie[0];
  wire [3:0] req_p = {req_ser, req_ccp, req_tm2, req_tm1};
  wire req_per = ctrl_en[`IEFL_BIT_PERIPHERAL_MASTER_ENABLE] && (|req_p);
  wire next_core_irq = ctrl_en[`IEFL_BIT_GIE] && (req_t0 | req_ed | req_pc | req_per);
  wire next_irq = |(stat & stat_mask[`IEFL_NSRC-1:0]);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_en <= `IEFL_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_en <= {wdat[7:3], 3'h0};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pie <= `IEFL_PIE_RESET;
    end else if (wr_pie) begin
      pie <= wdat & `IEFL_PIE_WMASK;
    end
  end

  // Status mask, stored whole as written
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stat_mask <= `IEFL_ZERO8;
    end else if (wr_mask) begin
      stat_mask <= wdat;
    end
  end

  // Edge history resets to the idle level so no false edge follows reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      edge_prev <= 1'b0;
    end else begin
      edge_prev <= edge_sync;
    end
  end

  // Reading the control register re-arms the port compare
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      port_latch <= 4'h0;
    end else if (rd_ctrl) begin
      port_latch <= port_sync;
    end
  end

  // Answer in the cycle after setup: no wait states
  wire next_pready  = i_psel && !i_penable;
  wire next_pslverr = next_pready && !hit_any;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

  // Read data registered in setup cycle
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= `IEFL_ZERO32;
    end else if (setup_rd) begin
      o_prdata <= rd_mux;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_core_irq <= 1'b0;
    end else begin
      o_core_irq <= next_core_irq;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= next_irq;
    end
  end
endmodule

/* File: test/iefl_asserts.sv */
// Port-level assertions for the interrupt enable and flag block
`timescale 1ns/1ns
`include "iefl_params.svh"
module iefl_asserts (
  input wire logic                 i_clk,
  input wire logic                 i_nrst,
  input wire logic                 i_psel,
  input wire logic                 i_penable,
  input wire logic                 i_pwrite,
  input wire iefl_pkg::iefl_addr_t i_paddr,
  input wire iefl_pkg::iefl_word_t i_pwdata,
  input wire iefl_pkg::iefl_word_t o_prdata,
  input wire logic                 o_pready,
  input wire logic                 o_pslverr,
  input wire logic                 i_timer_zero_overflow,
  input wire logic                 i_serial_port_event,
  input wire logic                 o_core_irq
);
  import iefl_pkg::*;
  // Shadow of the enable bits, so request gating can be judged from the ports
  iefl_byte_t c;
  iefl_byte_t p;
  wire setup = i_psel && !i_penable;
  wire wr    = i_psel && i_penable && i_pwrite;
  wire known = i_paddr inside {`IEFL_ADDR_CTRL, `IEFL_ADDR_PIE, `IEFL_ADDR_PFLAG, `IEFL_ADDR_STAT, `IEFL_ADDR_MASK};
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      c <= 8'h00;
      p <= 8'h00;
    end else if (wr && i_paddr == `IEFL_ADDR_CTRL) begin
      c <= i_pwdata[7:0];
    end else if (wr && i_paddr == `IEFL_ADDR_PIE) begin
      p <= i_pwdata[7:0];
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  answer_next_a: assert property (setup |=> o_pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  err_unmapped_a: assert property (setup && !known |=> o_pslverr)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (setup && known |=> !o_pslverr)
    else $error("mapped access refused");
  pie_read_a: assert property (o_pready && !i_pwrite && i_paddr == `IEFL_ADDR_PIE
    |-> o_prdata == {24'h000000, p & `IEFL_PIE_WMASK}) else $error("peripheral enable readback");
  gie_block_a: assert property (!c[7] |=> !o_core_irq)
    else $error("request with global enable off");
  peri_block_a: assert property (!c[6] && c[5:3] == 3'h0 |=> !o_core_irq)
    else $error("peripheral request without master enable");
  t0_raise_a: assert property (i_timer_zero_overflow && c[7] && c[5] && !i_psel |-> ##2 o_core_irq)
    else $error("timer overflow request missing");
  ser_raise_a: assert property (i_serial_port_event && c[7:6] == 2'h3 && p[3] && !i_psel
    |-> ##2 o_core_irq) else $error("serial request missing");
endmodule
bind iefl_top iefl_asserts chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_timer_zero_overflow(i_timer_zero_overflow),
  .i_serial_port_event(i_serial_port_event), .o_core_irq(o_core_irq));

/* File: test/iefl_src_model.sv */
// Event sources: timer zero, serial, capture/compare, timer two, timer one
`timescale 1ns/1ns
module iefl_src_model (
  input wire logic  i_clk,
  output logic [4:0] o_pulse
);
  initial o_pulse = 5'h00;
  task automatic fire(input int k);
    o_pulse[k] <= 1'b1;
    @(posedge i_clk);
    o_pulse[k] <= 1'b0;
  endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the interrupt enable and flag block
`timescale 1ns/1ns
`include "iefl_params.svh"
module tb;
  import iefl_pkg::*;
  logic       clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, pin = 0, en, er;
  logic [3:0] up = 4'h0;
  logic [4:0] ev;
  logic       rdy, err, cirq, irq;
  iefl_addr_t a = 12'h000;
  iefl_word_t wd = 32'h0, prd, rd;
  int         fails = 0, checks_done = 0, seed = 22720;
  always #4 clk = ~clk;
  iefl_src_model src (.i_clk(clk), .o_pulse(ev));
  iefl_top dut (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(a),
    .i_pwdata(wd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_timer_zero_overflow(ev[0]),
    .i_external_edge_pin(pin), .i_edge_rising(1'b1), .i_upper_port_pins(up), .i_serial_port_event(ev[1]),
    .i_capture_compare_one_event(ev[2]), .i_timer_two_match_event(ev[3]),
    .i_timer_one_overflow_event(ev[4]), .o_core_irq(cirq), .o_irq(irq));
  task automatic close_out;
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Upper data bits are random; only the low byte may matter
  task automatic bus(input logic w, input iefl_addr_t ad, input iefl_byte_t d);
    int n;
    psel <= 1'b1;
    pwr <= w;
    a <= ad;
    wd <= {24'($random(seed)), d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    rd = prd;
    er = err;
    if (n >= 50) begin
      fails++;
      close_out();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    tick(8);
    nrst <= 1'b1;
    tick(1);
    bus(1'b0, `IEFL_ADDR_CTRL, 8'h00);
    chk("control", 32'h0, rd);
    bus(1'b0, `IEFL_ADDR_PIE, 8'h00);
    chk("periph enable", 32'h0, rd);
    bus(1'b1, `IEFL_ADDR_PIE, 8'h3f);
    bus(1'b0, `IEFL_ADDR_PIE, 8'h00);
    chk("periph enable", 32'h0f, rd);
    bus(1'b0, 12'h040, 8'h00);
    chk("unmapped", 32'h1, {rd[30:0], er});
    bus(1'b1, `IEFL_ADDR_CTRL, 8'h80);
    src.fire(0);
    tick(2);
    chk("core irq", 32'h0, cirq);
    bus(1'b0, `IEFL_ADDR_CTRL, 8'h00);
    chk("control", 32'h84, rd);
    bus(1'b1, `IEFL_ADDR_CTRL, 8'ha0);
    bus(1'b0, `IEFL_ADDR_CTRL, 8'h00);
    chk("control", 32'ha0, rd);
    src.fire(0);
    tick(2);
    chk("core irq", 32'h1, cirq);
    bus(1'b1, `IEFL_ADDR_CTRL, 8'h24);
    tick(2);
    chk("core irq", 32'h0, cirq);
    bus(1'b0, `IEFL_ADDR_CTRL, 8'h00);
    chk("control", 32'h24, rd);
    bus(1'b1, `IEFL_ADDR_MASK, 8'h7f);
    for (int i = 0; i < 4; i++) begin
      en = (i == 0) || $random(seed) % 2 != 0;
      bus(1'b1, `IEFL_ADDR_PIE, 8'(en) << (3 - i));
      bus(1'b1, `IEFL_ADDR_CTRL, 8'hc0);
      src.fire(i + 1);
      tick(2);
      chk("core irq", 32'(en), cirq);
      chk("irq", 32'h1, irq);
      bus(1'b1, `IEFL_ADDR_CTRL, 8'h80);
      tick(2);
      chk("core irq", 32'h0, cirq);
      bus(1'b1, `IEFL_ADDR_PFLAG, 8'h00);
      bus(1'b1, `IEFL_ADDR_STAT, 8'hff);
      tick(2);
      chk("irq", 32'h0, irq);
    end
    pin <= 1'b1;
    up <= 4'($random(seed)) | 4'h8;
    tick(12);
    bus(1'b0, `IEFL_ADDR_CTRL, 8'h00);
    chk("control", 32'h83, rd);
    bus(1'b1, `IEFL_ADDR_CTRL, 8'h93);
    tick(2);
    chk("core irq", 32'h1, cirq);
    bus(1'b1, `IEFL_ADDR_CTRL, 8'h89);
    tick(2);
    chk("core irq", 32'h1, cirq);
    bus(1'b1, `IEFL_ADDR_MASK, 8'h00);
    src.fire(4);
    tick(2);
    chk("irq", 32'h0, irq);
    close_out();
  end
endmodule
